//--- dmsp_serial_port.sv
// dual mode serial port with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "dmsp_params.svh"

module dmsp_serial_port (
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output var  logic [31:0] avs_readdata_out,
	output var  logic        avs_waitrequest_out,
	input  wire logic        rxd_in,
	input  wire logic        ext_clk_in,
	output var  logic        txd_out,
	output var  logic        sclk_out,
	output var  logic        sclk_oe_out,
	output var  logic        irq_out,
	output var  logic        rx_req_out,
	output var  logic        tx_req_out
);

	dmsp_pkg::dmsp_state_s s;
	dmsp_pkg::dmsp_state_s n;
	logic        tick;
	logic        sync;
	logic        mp;
	logic        par_on;
	logic [2:0]  last_bit;
	logic        tx_end;
	logic        rx_mid;
	logic        rx_end;
	logic        sync_go;
	logic        deliver;
	logic        fe_ev;
	logic        pe_ev;
	logic [4:0]  ev;
	logic [4:0]  w1c;
	logic [31:0] rd_val;
	logic [7:0]  tx_data;

	function automatic logic [11:0] dmsp_baud_div(input logic [2:0] sel);
		case (sel)
			3'h0: dmsp_baud_div = `DMSP_BAUD0;
			3'h1: dmsp_baud_div = `DMSP_BAUD1;
			3'h2: dmsp_baud_div = `DMSP_BAUD2;
			3'h3: dmsp_baud_div = `DMSP_BAUD3;
			3'h4: dmsp_baud_div = `DMSP_BAUD4;
			3'h5: dmsp_baud_div = `DMSP_BAUD5;
			3'h6: dmsp_baud_div = `DMSP_BAUD6;
			default: dmsp_baud_div = `DMSP_BAUD7;
		endcase
	endfunction : dmsp_baud_div

	function automatic logic [31:0] dmsp_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] bm;
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		dmsp_merge = (old & ~bm) | (wd & bm);
	endfunction : dmsp_merge

	always_comb begin
		n = s;
		ev = 5'h00;
		w1c = 5'h00;
		deliver = 1'b0;
		fe_ev = 1'b0;
		pe_ev = 1'b0;
		sync_go = 1'b0;
		rd_val = 32'h0000_0000;
		sync = (s.ctrl.mode == dmsp_pkg::MODE_SYNC);
		mp = (s.ctrl.mode == dmsp_pkg::MODE_MP);
		par_on = s.ctrl.par_en && !sync && !mp;
		last_bit = (!sync && !mp && !s.ctrl.len8) ? 3'h6 : 3'h7;
		tx_data = s.ctrl.len8 || sync || mp ? s.tx_buf : {1'b0, s.tx_buf[6:0]};
		n.bcnt = (s.bcnt == 12'h000) ? dmsp_baud_div(s.ctrl.baud_sel) - 12'h001
			: s.bcnt - 12'h001;
		n.tmr = (s.tmr == 16'h0000) ? s.reload : s.tmr - 16'h0001;
		n.ext_q = ext_clk_in;
		case (s.ctrl.clk_src)
			2'h0: tick = (s.bcnt == 12'h000);
			2'h1: tick = ext_clk_in && !s.ext_q;
			2'h2: tick = (s.tmr == 16'h0000);
			default: tick = 1'b0;
		endcase
		tx_end = tick && (s.tx_ph == `DMSP_SUB_LAST);
		rx_mid = tick && (s.rx_ph == `DMSP_SUB_MID);
		rx_end = tick && (s.rx_ph == `DMSP_SUB_LAST);

		if (s.tx_st != dmsp_pkg::TX_IDLE && tick) begin
			n.tx_ph = s.tx_ph + 4'h1;
		end
		case (s.tx_st)
			dmsp_pkg::TX_IDLE: begin
				if (tick && s.tx_full && s.ctrl.tx_en) begin
					n.tx_sh = tx_data;
					n.tx_full = 1'b0;
					n.tx_par = mp ? s.ctrl.mp_addr : (^tx_data) ^ s.ctrl.par_odd;
					n.tx_ph = 4'h0;
					n.tx_bit = 3'h0;
					n.tx_st = sync ? dmsp_pkg::TX_DATA : dmsp_pkg::TX_START;
					sync_go = sync && s.ctrl.rx_en;
				end
			end
			dmsp_pkg::TX_START: begin
				if (tx_end) begin
					n.tx_st = dmsp_pkg::TX_DATA;
				end
			end
			dmsp_pkg::TX_DATA: begin
				if (tx_end) begin
					n.tx_sh = {1'b0, s.tx_sh[7:1]};
					n.tx_bit = s.tx_bit + 3'h1;
					if (s.tx_bit == last_bit) begin
						if (sync) begin
							n.tx_st = dmsp_pkg::TX_IDLE;
							ev[`DMSP_ST_TXDONE] = 1'b1;
						end else begin
							n.tx_st = (par_on || mp) ? dmsp_pkg::TX_PAR : dmsp_pkg::TX_STOP;
						end
					end
				end
			end
			dmsp_pkg::TX_PAR: begin
				if (tx_end) begin
					n.tx_st = dmsp_pkg::TX_STOP;
				end
			end
			dmsp_pkg::TX_STOP: begin
				if (tx_end) begin
					n.tx_st = dmsp_pkg::TX_IDLE;
					ev[`DMSP_ST_TXDONE] = 1'b1;
				end
			end
			default: n.tx_st = dmsp_pkg::TX_IDLE;
		endcase

		// register slave, one wait cycle
		case (avs_address_in)
			`DMSP_OFS_CTRL: rd_val = {19'h0, s.ctrl};
			`DMSP_OFS_STAT: rd_val = {21'h0, s.rx_full, s.tx_full,
				s.tx_st != dmsp_pkg::TX_IDLE, 3'h0, s.status};
			`DMSP_OFS_MASK: rd_val = {27'h0, s.mask};
			`DMSP_OFS_TXD: rd_val = {24'h0, s.tx_buf};
			`DMSP_OFS_RXD: rd_val = {23'h0, s.rx_buf};
			`DMSP_OFS_RLD: rd_val = {16'h0, s.reload};
			default: rd_val = 32'h0000_0000;
		endcase
		if ((avs_read_in || avs_write_in) && s.wait_r) begin
			n.wait_r = 1'b0;
			n.rdata = rd_val;
		end else if ((avs_read_in || avs_write_in) && !s.wait_r) begin
			n.wait_r = 1'b1;
			if (avs_write_in) begin
				case (avs_address_in)
					`DMSP_OFS_CTRL: n.ctrl = dmsp_pkg::dmsp_ctrl_s'(13'(
						dmsp_merge({19'h0, s.ctrl}, avs_writedata_in, avs_byteenable_in)));
					`DMSP_OFS_STAT: w1c = avs_writedata_in[4:0] & {5{avs_byteenable_in[0]}};
					`DMSP_OFS_MASK: n.mask = 5'(dmsp_merge({27'h0, s.mask}, avs_writedata_in,
						avs_byteenable_in));
					`DMSP_OFS_TXD: begin
						if (avs_byteenable_in[0] && !n.tx_full) begin
							n.tx_buf = avs_writedata_in[7:0];
							n.tx_full = 1'b1;
						end
					end
					`DMSP_OFS_RLD: n.reload = 16'(dmsp_merge({16'h0, s.reload}, avs_writedata_in,
						avs_byteenable_in));
					default: n.wait_r = 1'b1;
				endcase
			end else if (avs_address_in == `DMSP_OFS_RXD) begin
				n.rx_full = 1'b0;
			end
		end

		if (s.rx_st != dmsp_pkg::RX_IDLE && tick) begin
			n.rx_ph = s.rx_ph + 4'h1;
		end
		case (s.rx_st)
			dmsp_pkg::RX_IDLE: begin
				if (sync_go) begin
					n.rx_st = dmsp_pkg::RX_DATA;
					n.rx_ph = 4'h0;
					n.rx_bit = 3'h0;
					n.rx_sh = 8'h00;
				end else if (!sync && s.ctrl.rx_en && tick && !rxd_in) begin
					n.rx_st = dmsp_pkg::RX_START;
					n.rx_ph = 4'h0;
					n.rx_bit = 3'h0;
					n.rx_sh = 8'h00;
				end
			end
			dmsp_pkg::RX_START: begin
				if (rx_mid && rxd_in) begin
					n.rx_st = dmsp_pkg::RX_IDLE;
				end else if (rx_end) begin
					n.rx_st = dmsp_pkg::RX_DATA;
				end
			end
			dmsp_pkg::RX_DATA: begin
				if (rx_mid) begin
					n.rx_sh[s.rx_bit] = rxd_in;
				end
				if (rx_end) begin
					n.rx_bit = s.rx_bit + 3'h1;
					if (s.rx_bit == last_bit) begin
						if (sync) begin
							deliver = 1'b1;
							n.rx_st = dmsp_pkg::RX_IDLE;
						end else begin
							n.rx_st = (par_on || mp) ? dmsp_pkg::RX_PAR : dmsp_pkg::RX_STOP;
						end
					end
				end
			end
			dmsp_pkg::RX_PAR: begin
				if (rx_mid) begin
					n.rx_par = rxd_in;
				end
				if (rx_end) begin
					n.rx_st = dmsp_pkg::RX_STOP;
				end
			end
			dmsp_pkg::RX_STOP: begin
				if (rx_mid) begin
					deliver = 1'b1;
					fe_ev = !rxd_in;
					pe_ev = par_on && (s.rx_par != ((^s.rx_sh) ^ s.ctrl.par_odd));
					n.rx_st = dmsp_pkg::RX_IDLE;
				end
			end
			default: n.rx_st = dmsp_pkg::RX_IDLE;
		endcase
		if (deliver) begin
			ev[`DMSP_ST_FE] = fe_ev;
			ev[`DMSP_ST_PE] = pe_ev;
			if (n.rx_full) begin
				ev[`DMSP_ST_ORE] = 1'b1;
			end else begin
				n.rx_buf = {mp ? s.rx_par : 1'b0, s.rx_sh};
				n.rx_full = 1'b1;
				ev[`DMSP_ST_RXDONE] = 1'b1;
			end
		end

		n.status = (s.status & ~w1c) | ev;
		n.irq = |(n.status & n.mask);
		n.rx_irq = |(n.status & n.mask & `DMSP_ST_RXMASK);
		n.tx_irq = |(n.status & n.mask & `DMSP_ST_TXMASK);
		case (n.tx_st)
			dmsp_pkg::TX_START: n.txd = 1'b0;
			dmsp_pkg::TX_DATA: n.txd = n.tx_sh[0];
			dmsp_pkg::TX_PAR: n.txd = n.tx_par;
			default: n.txd = 1'b1;
		endcase
		n.sclk = !(n.tx_st == dmsp_pkg::TX_DATA && n.ctrl.mode == dmsp_pkg::MODE_SYNC
			&& n.tx_ph < `DMSP_SCLK_HI);
		n.sclk_oe = (n.ctrl.mode == dmsp_pkg::MODE_SYNC);
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			s <= '0;
			s.ctrl <= `DMSP_CTRL_RST;
			s.reload <= `DMSP_RLD_RST;
			s.tx_st <= dmsp_pkg::TX_IDLE;
			s.rx_st <= dmsp_pkg::RX_IDLE;
			s.txd <= 1'b1;
			s.sclk <= 1'b1;
			s.wait_r <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign avs_readdata_out = s.rdata;
	assign avs_waitrequest_out = s.wait_r;
	assign txd_out = s.txd;
	assign sclk_out = s.sclk;
	assign sclk_oe_out = s.sclk_oe;
	assign irq_out = s.irq;
	assign rx_req_out = s.rx_irq;
	assign tx_req_out = s.tx_irq;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);

	AST_SYNC_NO_FRAME: assert property (
		sync && s.tx_st != dmsp_pkg::TX_IDLE |-> s.tx_st == dmsp_pkg::TX_DATA)
		else $error("sync transfer left the data state");
	AST_START_LOW: assert property (
		s.tx_st == dmsp_pkg::TX_START |-> !txd_out)
		else $error("start bit not low");
	AST_STOP_HIGH: assert property (
		s.tx_st == dmsp_pkg::TX_STOP |-> txd_out)
		else $error("stop bit not high");
	AST_NRZ_HOLD: assert property (
		!tick |=> $stable(txd_out))
		else $error("line changed without a bit tick");
	AST_TX_DONE: assert property (
		s.tx_st == dmsp_pkg::TX_STOP && tx_end |=> s.status[`DMSP_ST_TXDONE])
		else $error("send complete not flagged");
	AST_RX_IRQ: assert property (
		|(s.status & s.mask & `DMSP_ST_RXMASK) |-> rx_req_out && irq_out)
		else $error("receive request missing");
	AST_OVERRUN: assert property (
		deliver && n.rx_full && s.rx_full |=> s.status[`DMSP_ST_ORE] && $stable(s.rx_buf))
		else $error("overrun not flagged or data lost");
	AST_MP_NO_PARITY: assert property (
		mp |-> !pe_ev)
		else $error("parity error in multiprocessor mode");
	AST_SEVEN_BIT: assert property (
		deliver && last_bit == 3'h6 && !n.rx_full |=> !s.rx_buf[7])
		else $error("seven bit character has bit 7 set");
	AST_BUS_WAIT: assert property (
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("waitrequest held longer than one cycle");

endmodule : dmsp_serial_port
`default_nettype wire

//--- dmsp_params.svh
// offsets, field positions, reset values and counts of the serial port
`ifndef DMSP_PARAMS_SVH
`define DMSP_PARAMS_SVH

`define DMSP_ADDR_W      5
`define DMSP_OFS_CTRL    5'h00
`define DMSP_OFS_STAT    5'h04
`define DMSP_OFS_MASK    5'h08
`define DMSP_OFS_TXD     5'h0C
`define DMSP_OFS_RXD     5'h10
`define DMSP_OFS_RLD     5'h14

`define DMSP_CTRL_W      13
`define DMSP_CTRL_RST    13'h0000
`define DMSP_RLD_RST     16'h0000

`define DMSP_ST_RXDONE   0
`define DMSP_ST_TXDONE   1
`define DMSP_ST_FE       2
`define DMSP_ST_ORE      3
`define DMSP_ST_PE       4
`define DMSP_ST_RXMASK   5'h1D
`define DMSP_ST_TXMASK   5'h02

`define DMSP_SUB_LAST    4'hF
`define DMSP_SUB_MID     4'h7
`define DMSP_SCLK_HI     4'h8

`define DMSP_BAUD0       12'hCB7
`define DMSP_BAUD1       12'h65C
`define DMSP_BAUD2       12'h32E
`define DMSP_BAUD3       12'h197
`define DMSP_BAUD4       12'h0CB
`define DMSP_BAUD5       12'h06D
`define DMSP_BAUD6       12'h036
`define DMSP_BAUD7       12'h01B

`endif

//--- dmsp_pkg.sv
// types of the serial port
package dmsp_pkg;

	typedef enum logic [1:0] {
		MODE_ASYNC = 2'h0,
		MODE_MP    = 2'h1,
		MODE_SYNC  = 2'h2
	} dmsp_mode_e;

	typedef enum logic [4:0] {
		TX_IDLE  = 5'h01,
		TX_START = 5'h02,
		TX_DATA  = 5'h04,
		TX_PAR   = 5'h08,
		TX_STOP  = 5'h10
	} dmsp_tx_e;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_PAR   = 5'h08,
		RX_STOP  = 5'h10
	} dmsp_rx_e;

	typedef struct packed {
		logic       mp_addr;
		logic       rx_en;
		logic       tx_en;
		logic [2:0] baud_sel;
		logic [1:0] clk_src;
		logic       par_odd;
		logic       par_en;
		logic       len8;
		dmsp_mode_e mode;
	} dmsp_ctrl_s;

	typedef struct packed {
		dmsp_ctrl_s  ctrl;
		logic [4:0]  status;
		logic [4:0]  mask;
		logic [15:0] reload;
		logic [15:0] tmr;
		logic [11:0] bcnt;
		logic        ext_q;
		dmsp_tx_e    tx_st;
		logic [7:0]  tx_buf;
		logic        tx_full;
		logic [7:0]  tx_sh;
		logic        tx_par;
		logic [3:0]  tx_ph;
		logic [2:0]  tx_bit;
		logic        txd;
		logic        sclk;
		logic        sclk_oe;
		dmsp_rx_e    rx_st;
		logic [7:0]  rx_sh;
		logic        rx_par;
		logic [3:0]  rx_ph;
		logic [2:0]  rx_bit;
		logic [8:0]  rx_buf;
		logic        rx_full;
		logic [31:0] rdata;
		logic        wait_r;
		logic        irq;
		logic        rx_irq;
		logic        tx_irq;
	} dmsp_state_s;

endpackage : dmsp_pkg

//--- dmsp_serial_peer.sv
// far side serial device model for the serial port
`timescale 1ns/1ps
`default_nettype none

module dmsp_serial_peer #(
	parameter int BIT_CYC = 64
) (
	input  wire logic clk_in,
	input  wire logic sclk_in,
	input  wire logic line_in,
	output var  logic line_out
);
	logic [7:0] rx_byte;
	logic [7:0] sy_byte;
	int         rx_cnt;

	initial begin
		line_out = 1'b1;
		rx_byte = 8'h00;
		sy_byte = 8'h00;
		rx_cnt = 0;
	end

	task send_char(input logic [7:0] d, input int nb, input logic xb_en, input logic xb,
		input logic stop_b);
		int i;
		@(posedge clk_in);
		line_out <= 1'b0;
		repeat (BIT_CYC) @(posedge clk_in);
		for (i = 0; i < nb; i++) begin
			line_out <= d[i];
			repeat (BIT_CYC) @(posedge clk_in);
		end
		if (xb_en) begin
			line_out <= xb;
			repeat (BIT_CYC) @(posedge clk_in);
		end
		line_out <= stop_b;
		repeat (BIT_CYC) @(posedge clk_in);
		line_out <= 1'b1;
		repeat (2 * BIT_CYC) @(posedge clk_in);
	endtask : send_char

	task sync_char(input logic [7:0] d);
		int j;
		for (j = 0; j < 8; j++) begin
			@(negedge sclk_in);
			line_out <= d[j];
			@(posedge sclk_in);
			sy_byte[j] = line_in;
		end
		line_out <= 1'b1;
	endtask : sync_char

	always begin
		@(negedge line_in);
		repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk_in);
		for (int k = 0; k < 8; k++) begin
			rx_byte[k] = line_in;
			repeat (BIT_CYC) @(posedge clk_in);
		end
		rx_cnt++;
	end
endmodule : dmsp_serial_peer

`default_nettype wire

//--- dmsp_serial_port_tb.sv
// self-checking testbench of the serial port
`timescale 1ns/1ps
`default_nettype none
`include "dmsp_params.svh"

module dmsp_serial_port_tb;
	logic        clk_sys_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [4:0]  avs_address_in = 5'h00;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        rxd_in;
	logic        txd_out;
	logic        sclk_out;
	logic        sclk_oe_out;
	logic [1:0]  ext_div = 2'h0;
	logic        irq_out;
	logic        rx_req_out;
	logic        tx_req_out;
	logic [31:0] rd;
	int          mismatches = 0;
	int          num_checks = 0;
	int          cyc = 0;

	always #2.5 clk_sys_in = ~clk_sys_in;

	// outside bit clock, four cycles a sub-tick
	always @(posedge clk_sys_in) begin
		ext_div <= ext_div + 2'h1;
	end

	dmsp_serial_port dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .rxd_in(rxd_in), .ext_clk_in(ext_div[1]),
		.txd_out(txd_out), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out), .irq_out(irq_out),
		.rx_req_out(rx_req_out), .tx_req_out(tx_req_out));

	dmsp_serial_peer #(.BIT_CYC(64)) peer (.clk_in(clk_sys_in), .sclk_in(sclk_out),
		.line_in(txd_out), .line_out(rxd_in));

	task final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches++;
			final_report();
		end
	end

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask : chk

	task bus_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= 1'b1;
		do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
		avs_write_in <= 1'b0;
	endtask : bus_wr

	task bus_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		avs_address_in <= a;
		avs_read_in <= 1'b1;
		do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
		d = avs_readdata_out;
		avs_read_in <= 1'b0;
	endtask : bus_rd

	task poll_stat(input int b);
		int n;
		n = 0;
		do begin
			bus_rd(5'h04, rd);
			n++;
		end while (rd[b] !== 1'b1 && n < 2000);
	endtask : poll_stat

	task t_reset();
		chk("txd idle", 32'h1, {31'h0, txd_out});
		chk("irq idle", 32'h0, {31'h0, irq_out});
		chk("sclk drive idle", 32'h0, {31'h0, sclk_oe_out});
		bus_rd(5'h00, rd);
		chk("ctrl", 32'h0, rd);
		bus_rd(5'h18, rd);
		chk("unmapped", 32'h0, rd);
	endtask : t_reset

	task t_tx();
		bus_wr(5'h14, 32'h3);
		bus_wr(5'h00, 32'hC44);
		bus_wr(5'h0C, 32'hA5);
		poll_stat(1);
		chk("line byte", 32'hA5, {24'h0, peer.rx_byte});
		chk("line chars", 32'h1, peer.rx_cnt);
		chk("masked irq", 32'h0, {31'h0, irq_out});
		bus_wr(5'h08, 32'h1F);
		bus_rd(5'h04, rd);
		chk("tx req", 32'h1, {31'h0, tx_req_out});
		chk("irq tx", 32'h1, {31'h0, irq_out});
		bus_wr(5'h04, 32'h02);
		bus_rd(5'h04, rd);
		chk("status clr", 32'h0, {27'h0, rd[4:0]});
		chk("irq clr", 32'h0, {31'h0, irq_out});
	endtask : t_tx

	task t_rx(input logic [31:0] ctl, input logic [7:0] d, input int nb, input logic xe,
		input logic xb, input logic sb, input logic [4:0] st, input logic [8:0] dat);
		bus_wr(5'h00, ctl);
		peer.send_char(d, nb, xe, xb, sb);
		poll_stat(0);
		chk("rx status", {27'h0, st}, {27'h0, rd[4:0]});
		chk("rx req", 32'h1, {31'h0, rx_req_out});
		bus_rd(5'h10, rd);
		chk("rx data", {23'h0, dat}, {23'h0, rd[8:0]});
		bus_wr(5'h04, 32'h1F);
	endtask : t_rx

	task t_baud();
		int n;
		n = 0;
		bus_wr(5'h00, 32'h784);
		bus_wr(5'h0C, 32'hFF);
		do @(posedge clk_sys_in); while (txd_out !== 1'b0);
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (txd_out === 1'b0);
		chk("start bit cycles", {16'h0000, `DMSP_BAUD7, 4'h0}, n);
		poll_stat(1);
		chk("baud status", 32'h02, {27'h0, rd[4:0]});
		bus_wr(5'h04, 32'h1F);
	endtask : t_baud

	task t_sync();
		bus_wr(5'h00, 32'hC42);
		fork
			peer.sync_char(8'h6B);
			bus_wr(5'h0C, 32'hD2);
		join
		chk("sclk drive", 32'h1, {31'h0, sclk_oe_out});
		chk("sync line", 32'hD2, {24'h0, peer.sy_byte});
		poll_stat(1);
		chk("sync status", 32'h03, {27'h0, rd[4:0]});
		bus_rd(5'h10, rd);
		chk("sync data", 32'h6B, {23'h0, rd[8:0]});
		chk("sclk idle", 32'h1, {31'h0, sclk_out});
		bus_wr(5'h04, 32'h1F);
	endtask : t_sync

	task t_overrun();
		peer.send_char(8'h11, 8, 1'b0, 1'b0, 1'b1);
		peer.send_char(8'h22, 8, 1'b0, 1'b0, 1'b1);
		poll_stat(3);
		chk("ore status", 32'h09, {27'h0, rd[4:0]});
		bus_rd(5'h10, rd);
		chk("ore data", 32'h11, {23'h0, rd[8:0]});
		bus_wr(5'h04, 32'h1F);
	endtask : t_overrun

	initial begin
		repeat (16) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		@(posedge clk_sys_in);
		t_reset();
		t_tx();
		t_rx(32'hC44, 8'h3C, 8, 1'b0, 1'b0, 1'b1, 5'h01, 9'h03C);
		t_rx(32'hC44, 8'h5A, 8, 1'b0, 1'b0, 1'b0, 5'h05, 9'h05A);
		t_overrun();
		t_rx(32'hC4C, 8'h01, 8, 1'b1, 1'b0, 1'b1, 5'h11, 9'h001);
		t_rx(32'hC4D, 8'h01, 8, 1'b1, 1'b1, 1'b1, 5'h01, 9'h101);
		t_rx(32'hC40, 8'h55, 7, 1'b0, 1'b0, 1'b1, 5'h01, 9'h055);
		t_rx(32'hC24, 8'h96, 8, 1'b0, 1'b0, 1'b1, 5'h01, 9'h096);
		t_baud();
		t_sync();
		final_report();
	end
endmodule : dmsp_serial_port_tb

`default_nettype wire
